/* include/otppv_regs.svh */
`ifndef OTPPV_REGS_SVH
`define OTPPV_REGS_SVH

// register byte offsets
`define OTPPV_ADDR_CFG_LO   8'h00
`define OTPPV_ADDR_CFG_HI   8'h04
`define OTPPV_ADDR_CTRL     8'h08
`define OTPPV_ADDR_STATUS   8'h0C
`define OTPPV_ADDR_RDATA    8'h10

// field widths and positions
`define OTPPV_CFG_LO_W      20
`define OTPPV_CFG_HI_W      19
`define OTPPV_STORE_W       40
`define OTPPV_WORD_W        10
`define OTPPV_NWORDS        4
`define OTPPV_CTRL_OP_LSB   0
`define OTPPV_CTRL_WSEL_LSB 2
`define OTPPV_CTRL_BIASL    4
`define OTPPV_CTRL_BIASH    5
`define OTPPV_ST_ACTIVE     0
`define OTPPV_ST_FAIL       1
`define OTPPV_ST_LOCK       2

// reset values
`define OTPPV_RST_WORD      32'h0000_0000
`define OTPPV_RST_CNT       16'h0000

// timing: clock period and operation durations in ns
`define OTPPV_CLK_NS        8
`define OTPPV_PROG_NS       2000
`define OTPPV_REF_NS        400

`endif

/* include/otppv_pkg.sv */
package otppv_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_REF  = 3'h2,
		ST_PROG = 3'h4
	} otppv_state_t;

	typedef enum logic [1:0] {
		OP_NOP0    = 2'h0,
		OP_REFRESH = 2'h1,
		OP_PROGRAM = 2'h2,
		OP_NOP3    = 2'h3
	} otppv_op_t;

endpackage

/* hw/otppv_sync.sv */
`timescale 1ns/1ps
module otppv_sync (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// level in and out
	input  wire logic d_async,
	output logic      q_sync
);
	logic meta_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_reg <= 1'b0;
			q_sync   <= 1'b0;
		end else begin
			meta_reg <= d_async;
			q_sync   <= meta_reg;
		end
	end
endmodule

/* hw/otppv_store.sv */
`timescale 1ns/1ps
`include "otppv_regs.svh"
module otppv_store (
	// clock and reset
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	// program port
	input  wire logic                      prog_req,
	input  wire logic                      prog_weak,
	input  wire logic [`OTPPV_STORE_W-1:0] prog_data,
	// refresh port
	input  wire logic                      ref_req,
	input  wire logic                      bias_l,
	input  wire logic                      bias_h,
	output logic      [`OTPPV_STORE_W-1:0] rd_data,
	output logic                           lock_q
);
	logic [`OTPPV_STORE_W-1:0] cell_reg;
	logic [`OTPPV_STORE_W-1:0] weak_reg;
	wire  [`OTPPV_STORE_W-1:0] burn_w;
	wire  [`OTPPV_STORE_W-1:0] margin_w;

	// a burned cell returns to zero only at reset; a locked array takes no burn
	assign burn_w = (prog_req && !cell_reg[`OTPPV_STORE_W-1]) ?
		prog_data : {`OTPPV_STORE_W{1'b0}};
	// cells burned under a sagging supply fail the high-margin read;
	// the low-margin bias alone still senses them
	assign margin_w = cell_reg & ~(weak_reg & {`OTPPV_STORE_W{bias_h}});

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cell_reg <= {`OTPPV_STORE_W{1'b0}};
			weak_reg <= {`OTPPV_STORE_W{1'b0}};
			rd_data  <= {`OTPPV_STORE_W{1'b0}};
			lock_q   <= 1'b0;
		end else begin
			cell_reg <= cell_reg | burn_w;
			weak_reg <= weak_reg | (burn_w & {`OTPPV_STORE_W{prog_weak}});
			lock_q   <= cell_reg[`OTPPV_STORE_W-1] |
				burn_w[`OTPPV_STORE_W-1];
			if (ref_req) begin
				rd_data <= margin_w;
			end
		end
	end
endmodule

/* hw/otppv_top.sv */
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "otppv_regs.svh"
// Behaviour
// [RULE1] host loads mapped config registers before programming
// [RULE2] operation code two burns config into store
// [RULE3] programming also sets the lock flag
// [RULE4] boost undervoltage during programming sets failure flag
// [RULE5] reading status clears the failure flag
// [RULE6] both margins set return exactly programmed content
// [RULE7] host verifies twice, each margin alone
// [RULE8] host passes only with no mismatched word
// [RULE9] code one refreshes all bits; zero, three idle
// [RULE10] read-back word is slice chosen by select
// [RULE11] programming refused once lock flag is set
// [RULE12] active bit high while any operation runs
module otppv_top
	import otppv_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// boost supply monitor, asynchronous
	input  wire logic        boost_supply_low
);
	localparam int PROG_CYC =
		(`OTPPV_PROG_NS + `OTPPV_CLK_NS - 1) / `OTPPV_CLK_NS;
	localparam int REF_CYC =
		(`OTPPV_REF_NS + `OTPPV_CLK_NS - 1) / `OTPPV_CLK_NS;
	localparam int PROG_END = PROG_CYC + 1;
	localparam int REF_END = REF_CYC + 1;
	localparam logic [15:0] PROG_CNT = PROG_CYC[15:0];
	localparam logic [15:0] REF_CNT = REF_CYC[15:0];
	localparam logic [15:0] CNT_ONE = 16'h0001;

	logic [`OTPPV_CFG_LO_W-1:0] cfg_lo_reg;
	logic [`OTPPV_CFG_HI_W-1:0] cfg_hi_reg;
	logic [1:0]                 wsel_reg;
	logic                       bias_l_reg;
	logic                       bias_h_reg;
	logic                       fail_reg;
	logic                       uv_seen_reg;
	logic                       prog_ok_reg;
	logic [`OTPPV_STORE_W-1:0]  prog_img_reg;
	otppv_state_t               state_reg;
	otppv_state_t               state_next;
	logic [15:0]                cnt_reg;
	logic [15:0]                cnt_next;
	logic                       wr_pend_reg;
	logic [7:0]                 wr_addr_reg;

	wire                        uv_s;
	wire                        lock_q;
	wire  [`OTPPV_STORE_W-1:0]  store_q;
	wire  [`OTPPV_WORD_W-1:0]   word_w [`OTPPV_NWORDS];
	wire  [`OTPPV_WORD_W-1:0]   word_sel_w;

	otppv_sync u_uv_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d_async (boost_supply_low),
		.q_sync  (uv_s)
	);

	// bus decode
	wire       addr_ok = hsel & htrans[1] & hready;
	wire       rd_acc = addr_ok & ~hwrite;
	wire       wr_acc = addr_ok & hwrite;
	wire [7:0] a_lo = haddr[7:0];
	wire       wr_cfg_lo = wr_pend_reg & (wr_addr_reg == `OTPPV_ADDR_CFG_LO);
	wire       wr_cfg_hi = wr_pend_reg & (wr_addr_reg == `OTPPV_ADDR_CFG_HI);
	wire       wr_ctrl = wr_pend_reg & (wr_addr_reg == `OTPPV_ADDR_CTRL);
	wire       rd_status = rd_acc & (a_lo == `OTPPV_ADDR_STATUS);
	wire [1:0] op_w = hwdata[`OTPPV_CTRL_OP_LSB +: 2];
	wire       idle_w = (state_reg == ST_IDLE);
	wire       busy_w = ~idle_w;
	wire       prog_w = (state_reg == ST_PROG);
	wire       last_w = busy_w & (cnt_reg == CNT_ONE);

	// [RULE9] refresh start, nops
	wire start_ref = wr_ctrl & idle_w & (op_w == OP_REFRESH);
	// [RULE11] refuse when locked
	wire start_prog = wr_ctrl & idle_w & (op_w == OP_PROGRAM) & ~lock_q;
	// [RULE2] burn at end of program
	wire burn_w = prog_w & last_w;
	wire ref_done = (state_reg == ST_REF) & last_w;
	// [RULE4] undervoltage while burning
	wire uv_hit = prog_w & uv_s;

	genvar gi;
	generate
		for (gi = 0; gi < `OTPPV_NWORDS; gi++) begin : g_word
			assign word_w[gi] =
				store_q[gi*`OTPPV_WORD_W +: `OTPPV_WORD_W];
		end
	endgenerate

	// [RULE10] select read-back slice
	assign word_sel_w = word_w[wsel_reg];

	wire [31:0] ctrl_rd = {26'h0, bias_h_reg, bias_l_reg, wsel_reg, 2'h0};
	// [RULE12] active while busy
	wire [31:0] stat_rd = {29'h0, lock_q, fail_reg, busy_w};
	wire [31:0] rd_mux =
		(a_lo == `OTPPV_ADDR_CFG_LO) ? {12'h0, cfg_lo_reg} :
		(a_lo == `OTPPV_ADDR_CFG_HI) ? {13'h0, cfg_hi_reg} :
		(a_lo == `OTPPV_ADDR_CTRL)   ? ctrl_rd :
		(a_lo == `OTPPV_ADDR_STATUS) ? stat_rd :
		(a_lo == `OTPPV_ADDR_RDATA)  ? {22'h0, word_sel_w} :
		`OTPPV_RST_WORD;

	// read data is set at the address phase so the slave never waits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata      <= `OTPPV_RST_WORD;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= wr_acc;
			wr_addr_reg <= a_lo;
			if (rd_acc) begin
				hrdata <= rd_mux;
			end
		end
	end

	// [RULE1] config words feed the burn image
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_lo_reg <= {`OTPPV_CFG_LO_W{1'b0}};
			cfg_hi_reg <= {`OTPPV_CFG_HI_W{1'b0}};
			wsel_reg   <= 2'h0;
			bias_l_reg <= 1'b0;
			bias_h_reg <= 1'b0;
		end else begin
			if (wr_cfg_lo) begin
				cfg_lo_reg <= hwdata[`OTPPV_CFG_LO_W-1:0];
			end
			if (wr_cfg_hi) begin
				cfg_hi_reg <= hwdata[`OTPPV_CFG_HI_W-1:0];
			end
			if (wr_ctrl) begin
				wsel_reg   <= hwdata[`OTPPV_CTRL_WSEL_LSB +: 2];
				bias_l_reg <= hwdata[`OTPPV_CTRL_BIASL];
				bias_h_reg <= hwdata[`OTPPV_CTRL_BIASH];
			end
		end
	end

	// sequencer
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start_ref) begin
					state_next = ST_REF;
					cnt_next   = REF_CNT;
				end else if (start_prog) begin
					state_next = ST_PROG;
					cnt_next   = PROG_CNT;
				end
			end
			ST_REF, ST_PROG: begin
				cnt_next = cnt_reg - CNT_ONE;
				if (last_w) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
				cnt_next   = `OTPPV_RST_CNT;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= `OTPPV_RST_CNT;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// image frozen at start so bus writes cannot tear a burn
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prog_img_reg <= {`OTPPV_STORE_W{1'b0}};
			uv_seen_reg  <= 1'b0;
			prog_ok_reg  <= 1'b0;
		end else begin
			// [RULE3] lock bit in image
			if (start_prog) begin
				prog_img_reg <= {1'b1, cfg_hi_reg, cfg_lo_reg};
			end
			uv_seen_reg <= ~start_prog & (uv_seen_reg | uv_hit);
			if (burn_w) begin
				prog_ok_reg <= ~(uv_seen_reg | uv_hit);
			end
		end
	end

	// [RULE5] clear on status read, set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fail_reg <= 1'b0;
		end else begin
			fail_reg <= uv_hit | (fail_reg & ~rd_status);
		end
	end

	// [RULE6] margin reads from store
	otppv_store u_store (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.prog_req  (burn_w),
		.prog_weak (uv_seen_reg | uv_hit),
		.prog_data (prog_img_reg),
		.ref_req   (ref_done),
		.bias_l    (bias_l_reg),
		.bias_h    (bias_h_reg),
		.rd_data   (store_q),
		.lock_q    (lock_q)
	);

	// every check runs on the bus clock and rests while in reset
	default clocking chk_clk @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_prog_burn: assert property ( // [RULE2]
		start_prog |-> ##PROG_END lock_q && idle_w)
		else $error("program did not burn on time");

	a_lock_set: assert property ( // [RULE3]
		$rose(lock_q) |-> $past(burn_w))
		else $error("lock rose outside a burn");

	a_lock_keep: assert property ( // [RULE3]
		lock_q |=> lock_q)
		else $error("lock flag fell without reset");

	a_fail_set: assert property ( // [RULE4]
		uv_hit |=> fail_reg)
		else $error("undervoltage during burn not flagged");

	a_fail_src: assert property ( // [RULE4]
		$rose(fail_reg) |-> $past(uv_hit))
		else $error("failure flag rose without undervoltage");

	a_fail_clr: assert property ( // [RULE5]
		rd_status && !uv_hit |=> !fail_reg)
		else $error("failure flag survived status read");

	a_fail_hold: assert property ( // [RULE5]
		fail_reg && !rd_status |=> fail_reg)
		else $error("failure flag cleared without status read");

	a_margin_read: assert property ( // [RULE6]
		ref_done && prog_ok_reg && bias_l_reg && bias_h_reg
		|=> store_q == prog_img_reg)
		else $error("margin refresh differs from burned image");

	a_nop_code: assert property ( // [RULE9]
		wr_ctrl && idle_w && (op_w == OP_NOP0 || op_w == OP_NOP3)
		|=> idle_w)
		else $error("nop code started an operation");

	a_ref_len: assert property ( // [RULE9]
		start_ref |=> busy_w ##(REF_CYC - 1) busy_w ##1 idle_w)
		else $error("refresh length wrong");

	a_word_slice: assert property ( // [RULE10]
		rd_acc && a_lo == `OTPPV_ADDR_RDATA
		|=> hrdata == {22'h0, $past(word_sel_w)})
		else $error("read-back slice wrong");

	a_lock_refuse: assert property ( // [RULE11]
		wr_ctrl && lock_q && op_w == OP_PROGRAM |=> !prog_w)
		else $error("program accepted while locked");

	a_active_hold: assert property ( // [RULE12]
		rd_acc && a_lo == `OTPPV_ADDR_STATUS
		|=> hrdata[`OTPPV_ST_ACTIVE] == $past(busy_w))
		else $error("active bit disagrees with sequencer");

	a_prog_busy: assert property ( // [RULE12]
		start_prog |=> busy_w ##(PROG_CYC - 1) busy_w ##1 idle_w)
		else $error("program busy span wrong");
endmodule

/* verif/otppv_host.sv */
`timescale 1ns/1ps
module otppv_host (
	// clock
	input  wire logic        hclk,
	// ahb-lite master side
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	initial begin
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// one single word transfer; waits on hready with no assumed latency
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		// stale write data is scrambled so nothing leans on it
		hwdata <= ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
`include "otppv_regs.svh"
module tb_top;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        boost_supply_low;
	int          fails;
	int          n_compared;
	int          bad_words;
	int          cyc = 0;
	logic [39:0] img;
	logic [31:0] q;

	otppv_top otppv_top_i (
		.hclk             (hclk),
		.hresetn          (hresetn),
		.hsel             (hsel),
		.haddr            (haddr),
		.htrans           (htrans),
		.hwrite           (hwrite),
		.hsize            (hsize),
		.hwdata           (hwdata),
		.hready           (hreadyout),
		.hrdata           (hrdata),
		.hreadyout        (hreadyout),
		.hresp            (hresp),
		.boost_supply_low (boost_supply_low)
	);

	otppv_host otppv_host_i (
		.hclk   (hclk),
		.hsel   (hsel),
		.haddr  (haddr),
		.htrans (htrans),
		.hwrite (hwrite),
		.hsize  (hsize),
		.hwdata (hwdata),
		.hready (hreadyout),
		.hrdata (hrdata)
	);

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	function automatic logic [31:0] exp_word(logic [39:0] m, int w);
		return {22'h0, m[w*10 +: 10]};
	endfunction

	// cells burned under a sagging boost supply read as zero once the
	// high-margin bias is on; the low-margin read still senses them
	function automatic logic [31:0] exp_read(int w, logic bh, logic wk);
		return exp_word((wk && bh) ? 40'h0 : img, w);
	endfunction

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		otppv_host_i.xfer(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a);
		otppv_host_i.xfer(1'b0, a, 32'h0, q);
	endtask

	// poll under a bound; the last status word is left in q
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			rd(`OTPPV_ADDR_STATUS);
			n++;
		end while (q[0] !== 1'b0 && n < 200);
		// a poll that runs out of tries counts as a mismatch
		chk("idle", 32'h0, {31'h0, q[0]});
	endtask

	task automatic prog(input logic [38:0] cfg, input logic uv);
		wr(`OTPPV_ADDR_CFG_LO, {12'h0, cfg[19:0]});
		wr(`OTPPV_ADDR_CFG_HI, {13'h0, cfg[38:20]});
		boost_supply_low <= uv;
		wr(`OTPPV_ADDR_CTRL, 32'h2);
		rd(`OTPPV_ADDR_STATUS);
		chk("active_prog", 32'h1, {31'h0, q[0]});
		wait_idle();
		boost_supply_low <= 1'b0;
		chk("fail_set", {31'h0, uv}, {31'h0, q[1]});
		rd(`OTPPV_ADDR_STATUS);
		chk("fail_clr", 32'h0, {31'h0, q[1]});
	endtask

	// one margin setting, every word select
	// wk marks a burn made under undervoltage
	task automatic verify(input logic bl, input logic bh, input logic wk);
		for (int w = 0; w < 4; w++) begin
			wr(`OTPPV_ADDR_CTRL, {26'h0, bh, bl, 2'(w), 2'h1});
			rd(`OTPPV_ADDR_STATUS);
			chk("active_ref", 32'h1, {31'h0, q[0]});
			wait_idle();
			rd(`OTPPV_ADDR_RDATA);
			chk("rdata", exp_read(w, bh, wk), q);
			if (q !== exp_word(img, w))
				bad_words++;
		end
	endtask

	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end

	initial begin
		hresetn = 1'b0;
		boost_supply_low = 1'b0;
		fails = 0;
		n_compared = 0;
		void'($urandom(32'h7a1a));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`OTPPV_ADDR_STATUS);
		chk("status_rst", 32'h0, q);
		chk("okay", 32'h2, {30'h0, hreadyout, hresp});
		rd(`OTPPV_ADDR_RDATA);
		chk("rdata_rst", 32'h0, q);
		wr(8'h14, $urandom);
		rd(8'h14);
		chk("unmapped", 32'h0, q);
		img = {1'b1, 7'($urandom), $urandom};
		prog(img[38:0], 1'b0);
		rd(`OTPPV_ADDR_STATUS);
		chk("lock_set", 32'h4, q);
		verify(1'b1, 1'b1, 1'b0);
		bad_words = 0;
		verify(1'b1, 1'b0, 1'b0);
		verify(1'b0, 1'b1, 1'b0);
		chk("judged", 32'h0, {31'h0, bad_words != 0});
		// no-operation codes leave the last refresh result in place
		for (int op = 0; op < 4; op += 3) begin
			wr(`OTPPV_ADDR_CTRL, 32'(op));
			rd(`OTPPV_ADDR_STATUS);
			chk("nop_idle", 32'h4, q);
			rd(`OTPPV_ADDR_RDATA);
			chk("nop_rdata", exp_word(img, 0), q);
		end
		// a second burn with new data must be refused
		wr(`OTPPV_ADDR_CFG_LO, ~{12'h0, img[19:0]});
		wr(`OTPPV_ADDR_CTRL, 32'h2);
		rd(`OTPPV_ADDR_STATUS);
		chk("refused", 32'h4, q);
		verify(1'b1, 1'b1, 1'b0);
		// fresh store, burn under boost undervoltage
		hresetn <= 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		img = {1'b1, 39'h55_5555_5555};
		prog(img[38:0], 1'b1);
		rd(`OTPPV_ADDR_STATUS);
		chk("lock_uv", 32'h4, q);
		// the high-margin pass must expose the weak burn
		bad_words = 0;
		verify(1'b1, 1'b0, 1'b1);
		verify(1'b0, 1'b1, 1'b1);
		chk("judged_uv", 32'h1, {31'h0, bad_words != 0});
		stop_test();
	end
endmodule
